// [inc/cce_pkg.sv]
package cce_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int FA_W = 5;
    localparam int LIT_W = 9;
    localparam int APB_AW = 12;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] ADDR_INSTR = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_ACC = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;
    localparam logic [APB_AW-1:0] ADDR_PC = 12'h00c;
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h010;
    localparam logic [APB_AW-1:0] ADDR_TOS = 12'h014;
    // File window 0x080..0x0fc, one register per word
    localparam logic [4:0] FILE_WIN_TAG = 5'h01;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IN_OP_LO = 0;
    localparam int IN_DEST_BIT = 3;
    localparam int IN_FA_LO = 4;
    localparam int IN_LIT_LO = 16;
    localparam int ST_Z_BIT = 2;
    localparam int ST_PD_BIT = 3;
    localparam int ST_TO_BIT = 4;
    localparam int ST_PAGE_LO = 5;
    localparam int CTRL_PSA_BIT = 0;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
    localparam logic [PC_W-1:0] RST_PC = 11'h000;
    localparam logic RST_Z = 1'h0;
    localparam logic RST_FLAG_N = 1'h1;
    localparam logic [1:0] RST_PAGE = 2'h0;
    localparam logic RST_PSA = 1'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        clear_accumulator_op = 3'h0,
        call_op = 3'h1,
        watchdog_clear_op = 3'h2,
        clear_file_op = 3'h3,
        complement_file_op = 3'h4,
        decrement_file_op = 3'h5,
        increment_file_op = 3'h6,
        jump_op = 3'h7
    } cce_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_EXEC = 4'h4,
        ST_BRANCH = 4'h8
    } cce_state_t;

    typedef struct packed {
        logic [LIT_W-1:0] lit;
        logic [FA_W-1:0] faddr;
        logic dest;
        cce_op_t op;
    } cce_instr_t;

    typedef struct packed {
        cce_state_t st;
        cce_instr_t ins;
        logic [DATA_W-1:0] acc;
        logic z;
        logic pd_n;
        logic to_n;
        logic [1:0] page;
        logic presc_wdt;
        logic [PC_W-1:0] pc;
        logic push;
        logic [PC_W-1:0] tos;
        logic wdt_clr;
        logic presc_clr;
        logic rd_ok;
        logic [31:0] prdata;
    } cce_core_t;

endpackage : cce_pkg

// [src/cce_exec.sv]
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module cce_exec
    import cce_pkg::*;
#(
    parameter int FILE_DEPTH = 32
) (
    // Clock, reset, enable
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [APB_AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Return stack
    output logic STACK_PUSH_OUT,
    output logic [PC_W-1:0] STACK_DATA_OUT,
    // Watchdog and prescaler
    output logic WDT_CLEAR_OUT,
    output logic PRESC_CLEAR_OUT,
    // Program counter
    output logic [PC_W-1:0] PC_OUT
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (FILE_DEPTH < 2 || FILE_DEPTH > (1 << FA_W)) begin : g_bad
            $error("cce_exec: FILE_DEPTH out of range");
        end
    endgenerate

    cce_core_t s_q;
    cce_core_t s_d;

    logic busy;
    logic access;
    logic file_hit;
    logic reg_hit;
    logic apb_ready;
    logic mem_we;
    logic [FA_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] res;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // File register bank
    // ------------------------------------------------------------
    cce_filemem #(
        .DW(DATA_W),
        .DEPTH(FILE_DEPTH),
        .AW(FA_W)
    ) u_mem (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .we_in(mem_we),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign busy = (s_q.st != ST_IDLE);
    assign access = PSEL_IN && PENABLE_IN;
    assign file_hit = (PADDR_IN[11:7] == FILE_WIN_TAG);
    assign reg_hit = (PADDR_IN == ADDR_INSTR) || (PADDR_IN == ADDR_ACC) ||
        (PADDR_IN == ADDR_STATUS) || (PADDR_IN == ADDR_PC) ||
        (PADDR_IN == ADDR_CTRL) || (PADDR_IN == ADDR_TOS);
    // Stall while executing, so bus writes never race the engine; a read
    // also waits until its data were captured with the engine idle
    assign apb_ready = !busy && (PWRITE_IN || s_q.rd_ok);

    // Register read mux, captured once the engine is idle
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (PADDR_IN)
            ADDR_INSTR: rd_mux[IN_LIT_LO +: 16] = 16'(s_q.ins);
            ADDR_ACC: rd_mux[DATA_W-1:0] = s_q.acc;
            ADDR_STATUS: begin
                rd_mux[ST_Z_BIT] = s_q.z;
                rd_mux[ST_PD_BIT] = s_q.pd_n;
                rd_mux[ST_TO_BIT] = s_q.to_n;
                rd_mux[ST_PAGE_LO +: 2] = s_q.page;
            end
            ADDR_PC: rd_mux[PC_W-1:0] = s_q.pc;
            ADDR_CTRL: rd_mux[CTRL_PSA_BIT] = s_q.presc_wdt;
            ADDR_TOS: rd_mux[PC_W-1:0] = s_q.tos;
            default: rd_mux = 32'h0000_0000;
        endcase
        if (PADDR_IN == ADDR_INSTR) begin
            rd_mux = 32'h0000_0000;
            rd_mux[IN_OP_LO +: 3] = s_q.ins.op;
            rd_mux[IN_DEST_BIT] = s_q.ins.dest;
            rd_mux[IN_FA_LO +: FA_W] = s_q.ins.faddr;
            rd_mux[IN_LIT_LO +: LIT_W] = s_q.ins.lit;
        end
    end

    // ------------------------------------------------------------
    // Result of the read-modify-write operations
    // ------------------------------------------------------------
    always_comb begin
        case (s_q.ins.op)
            complement_file_op: res = ~mem_rdata;
            // Wraps from 00 to ff
            decrement_file_op: res = mem_rdata - 8'h01;
            // Wraps from ff to 00
            increment_file_op: res = mem_rdata + 8'h01;
            default: res = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic: bus slave and execution engine
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.wdt_clr = 1'b0;
        s_d.presc_clr = 1'b0;
        mem_we = 1'b0;
        mem_wdata = 8'h00;
        mem_addr = busy ? s_q.ins.faddr : PADDR_IN[6:2];
        // Capture only when idle, so a read queued behind an instruction
        // sees its result; the file bank is addressed in the same cycle
        if (PSEL_IN && !PWRITE_IN && !busy && !s_q.rd_ok) begin
            s_d.prdata = rd_mux;
            s_d.rd_ok = 1'b1;
        end
        if (access && apb_ready) begin
            s_d.rd_ok = 1'b0;
            if (PWRITE_IN && file_hit) begin
                mem_we = 1'b1;
                mem_wdata = PWDATA_IN[DATA_W-1:0];
            end else if (PWRITE_IN) begin
                case (PADDR_IN)
                    ADDR_INSTR: begin
                        s_d.ins.op = cce_op_t'(PWDATA_IN[IN_OP_LO +: 3]);
                        s_d.ins.dest = PWDATA_IN[IN_DEST_BIT];
                        s_d.ins.faddr = PWDATA_IN[IN_FA_LO +: FA_W];
                        s_d.ins.lit = PWDATA_IN[IN_LIT_LO +: LIT_W];
                        if (PWDATA_IN[IN_OP_LO +: 3] >= 3'h4 &&
                            PWDATA_IN[IN_OP_LO +: 3] != 3'h7) begin
                            s_d.st = ST_READ;
                        end else begin
                            s_d.st = ST_EXEC;
                        end
                    end
                    ADDR_ACC: s_d.acc = PWDATA_IN[DATA_W-1:0];
                    ADDR_STATUS: begin
                        s_d.z = PWDATA_IN[ST_Z_BIT];
                        s_d.pd_n = PWDATA_IN[ST_PD_BIT];
                        s_d.to_n = PWDATA_IN[ST_TO_BIT];
                        s_d.page = PWDATA_IN[ST_PAGE_LO +: 2];
                    end
                    ADDR_CTRL: s_d.presc_wdt = PWDATA_IN[CTRL_PSA_BIT];
                    default: s_d.rd_ok = 1'b0;
                endcase
            end
        end
        case (s_q.st)
            ST_IDLE: s_d.rd_ok = s_d.rd_ok;
            // File operand is being fetched
            ST_READ: s_d.st = ST_EXEC;
            ST_EXEC: begin
                s_d.st = ST_IDLE;
                s_d.pc = PC_W'(s_q.pc + 11'h001);
                case (s_q.ins.op)
                    clear_accumulator_op: begin
                        s_d.acc = 8'h00;
                        s_d.z = 1'b1;
                    end
                    call_op: begin
                        s_d.push = 1'b1;
                        s_d.tos = PC_W'(s_q.pc + 11'h001);
                        s_d.pc = s_q.pc;
                        s_d.st = ST_BRANCH;
                    end
                    jump_op: begin
                        s_d.pc = s_q.pc;
                        s_d.st = ST_BRANCH;
                    end
                    watchdog_clear_op: begin
                        s_d.wdt_clr = 1'b1;
                        s_d.presc_clr = s_q.presc_wdt;
                        s_d.to_n = 1'b1;
                        s_d.pd_n = 1'b1;
                    end
                    clear_file_op: begin
                        mem_we = 1'b1;
                        mem_wdata = 8'h00;
                        s_d.z = 1'b1;
                    end
                    default: begin
                        if (s_q.ins.dest) begin
                            mem_we = 1'b1;
                            mem_wdata = res;
                        end else begin
                            s_d.acc = res;
                        end
                        s_d.z = (res == 8'h00);
                    end
                endcase
            end
            // second cycle of a branch, flags untouched
            ST_BRANCH: begin
                s_d.st = ST_IDLE;
                if (s_q.ins.op == call_op) begin
                    // low byte, page, bit 8 cleared
                    s_d.pc = {s_q.page, 1'b0, s_q.ins.lit[7:0]};
                end else begin
                    s_d.pc = {s_q.page, s_q.ins.lit};
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register; reset wins, otherwise enable low freezes everything
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.acc <= RST_ACC;
            s_q.z <= RST_Z;
            s_q.pd_n <= RST_FLAG_N;
            s_q.to_n <= RST_FLAG_N;
            s_q.page <= RST_PAGE;
            s_q.presc_wdt <= RST_PSA;
            s_q.pc <= RST_PC;
        end else if (CE_IN) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Handshake is combinational; a frozen block never answers
    assign PREADY_OUT = access && apb_ready && CE_IN;
    assign PSLVERR_OUT = access && apb_ready && CE_IN && !file_hit && !reg_hit;
    assign PRDATA_OUT = (file_hit && !PWRITE_IN) ?
        {24'h00_0000, mem_rdata} : s_q.prdata;
    assign STACK_PUSH_OUT = s_q.push;
    assign STACK_DATA_OUT = s_q.tos;
    assign WDT_CLEAR_OUT = s_q.wdt_clr;
    assign PRESC_CLEAR_OUT = s_q.presc_clr;
    assign PC_OUT = s_q.pc;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    logic ex_go;
    logic br_go;
    assign ex_go = CE_IN && (s_q.st == ST_EXEC);
    assign br_go = CE_IN && (s_q.st == ST_BRANCH);

    AST_CLR_ACC: assert property (
        ex_go && s_q.ins.op == clear_accumulator_op |=> s_q.acc == 8'h00 && s_q.z)
        else $error("accumulator clear failed");
    AST_PUSH: assert property (
        ex_go && s_q.ins.op == call_op |=> STACK_PUSH_OUT &&
        STACK_DATA_OUT == PC_W'($past(s_q.pc) + 11'h001))
        else $error("return address push wrong");
    AST_CALL_LOW: assert property (
        br_go && s_q.ins.op == call_op |=> PC_OUT[7:0] == $past(s_q.ins.lit[7:0]))
        else $error("call low byte wrong");
    AST_CALL_PAGE: assert property (
        br_go && s_q.ins.op == call_op |=>
        PC_OUT[10:9] == $past(s_q.page) && !PC_OUT[8])
        else $error("call page bits wrong");
    AST_CALL_TWO: assert property (
        ex_go && s_q.ins.op == call_op ##1 CE_IN |=> s_q.st == ST_IDLE &&
        {s_q.z, s_q.pd_n, s_q.to_n} == $past({s_q.z, s_q.pd_n, s_q.to_n}, 2))
        else $error("call length or flags wrong");
    AST_WDT: assert property (
        ex_go && s_q.ins.op == watchdog_clear_op |=> WDT_CLEAR_OUT)
        else $error("watchdog clear strobe missing");
    AST_PRESC: assert property (
        ex_go && s_q.ins.op == watchdog_clear_op |=>
        PRESC_CLEAR_OUT == $past(s_q.presc_wdt))
        else $error("prescaler clear wrong");
    AST_WDT_FLAGS: assert property (
        ex_go && s_q.ins.op == watchdog_clear_op |=>
        s_q.to_n && s_q.pd_n && s_q.z == $past(s_q.z))
        else $error("watchdog clear status wrong");
    AST_CLR_FILE: assert property (
        ex_go && s_q.ins.op == clear_file_op |-> mem_we && mem_wdata == 8'h00
        ##1 s_q.z)
        else $error("file clear failed");
    AST_COMP: assert property (
        ex_go && s_q.ins.op == complement_file_op && s_q.ins.dest |->
        mem_we && mem_wdata == ~mem_rdata)
        else $error("complement write-back wrong");
    AST_DEC: assert property (
        ex_go && s_q.ins.op == decrement_file_op && !s_q.ins.dest |=>
        s_q.acc == 8'($past(mem_rdata) - 8'h01))
        else $error("decrement result wrong");
    AST_INC: assert property (
        ex_go && s_q.ins.op == increment_file_op && !s_q.ins.dest |=>
        s_q.acc == 8'($past(mem_rdata) + 8'h01))
        else $error("increment result wrong");
    AST_ZERO: assert property (
        ex_go && s_q.ins.op >= complement_file_op && s_q.ins.op != jump_op
        |=> s_q.z == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    AST_JUMP: assert property (
        br_go && s_q.ins.op == jump_op |=>
        PC_OUT == {$past(s_q.page), $past(s_q.ins.lit)})
        else $error("jump target wrong");

    COV_CALL: cover property (br_go && s_q.ins.op == call_op);
    COV_WDT: cover property (ex_go && s_q.ins.op == watchdog_clear_op &&
        s_q.presc_wdt);
    COV_INC_WRAP: cover property (ex_go && s_q.ins.op == increment_file_op &&
        res == 8'h00);

endmodule : cce_exec

// [src/cce_filemem.sv]
`timescale 1ns/1ns
module cce_filemem #(
    parameter int DW = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // Clock and control
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Access port
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    output logic [DW-1:0] rdata_out
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
            $error("cce_filemem: DEPTH does not fit the address width");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [DW-1:0] rdata;
    } cce_mem_t;

    cce_mem_t s_q;
    cce_mem_t s_d;

    // Read before write, read data always registered
    always_comb begin
        s_d = s_q;
        if (32'(addr_in) < DEPTH) begin
            s_d.rdata = s_q.mem[addr_in];
            if (we_in) begin
                s_d.mem[addr_in] = wdata_in;
            end
        end else begin
            s_d.rdata = '0;
        end
    end

    // Reset clears the whole bank; small enough to afford it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;

endmodule : cce_filemem

// [testbench/cce_exec_tb_top.sv]
`timescale 1ns/1ns
module cce_exec_tb_top;
    import cce_pkg::*;

    // ------------------------------------------------------------
    // Signals and table row type
    // ------------------------------------------------------------
    typedef struct packed {
        cce_op_t op;
        logic dest;
        logic [4:0] fa;
        logic [7:0] init;
        logic [7:0] res;
        logic z;
    } cce_row_t;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic push, wdt_clr, presc_clr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [10:0] stk, pc, pc0;
    int fails, checks_done, n_wdt, n_presc, n_push;
    cce_row_t rows[8];
    cce_row_t r;

    cce_exec #(.FILE_DEPTH(32)) u_cce_exec (
        .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .STACK_PUSH_OUT(push), .STACK_DATA_OUT(stk),
        .WDT_CLEAR_OUT(wdt_clr), .PRESC_CLEAR_OUT(presc_clr), .PC_OUT(pc)
    );

    // ------------------------------------------------------------
    // Clock, strobe counters and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Sampled mid-cycle so registered strobes are settled
    always @(negedge clk) begin
        n_wdt += (wdt_clr === 1'b1);
        n_presc += (presc_clr === 1'b1);
        n_push += (push === 1'b1);
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 0, 1);
        test_done();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // APB transfer; pready and data taken at the accepting rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rdv = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] x;
        logic er;
        apb(1'b1, a, v, x, er);
    endtask : wr_reg
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic er;
        apb(1'b0, a, 32'h0, x, er);
        chk(x, exp);
    endtask : rd_chk
    function automatic logic [11:0] fad(input logic [4:0] f);
        return 12'h080 + {5'h0, f, 2'h0};
    endfunction : fad
    function automatic logic [31:0] mk(input cce_op_t op, input logic dst,
                                       input logic [4:0] f,
                                       input logic [8:0] lit);
        return {7'h0, lit, 7'h0, f, dst, op};
    endfunction : mk
    task automatic tend(input string s);
        $display("test %s done, fails=%0d", s, fails);
    endtask : tend
    task automatic test_done;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        // Boundary values: wrap both ways, zero results, both targets
        rows[0] = {complement_file_op, 1'b0, 5'h03, 8'h5a, 8'ha5, 1'b0};
        rows[1] = {complement_file_op, 1'b1, 5'h04, 8'hff, 8'h00, 1'b1};
        rows[2] = {decrement_file_op, 1'b0, 5'h05, 8'h01, 8'h00, 1'b1};
        rows[3] = {decrement_file_op, 1'b1, 5'h1f, 8'h00, 8'hff, 1'b0};
        rows[4] = {increment_file_op, 1'b0, 5'h06, 8'hff, 8'h00, 1'b1};
        rows[5] = {increment_file_op, 1'b1, 5'h00, 8'h7f, 8'h80, 1'b0};
        rows[6] = {clear_file_op, 1'b1, 5'h07, 8'h33, 8'h00, 1'b1};
        rows[7] = {clear_accumulator_op, 1'b0, 5'h08, 8'h44, 8'h00, 1'b1};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_ACC, 32'h0);
        rd_chk(ADDR_STATUS, 32'h18);
        chk({21'h0, pc}, 32'h0);
        tend("reset");
        foreach (rows[i]) begin
            r = rows[i];
            wr_reg(fad(r.fa), {24'h0, r.init});
            wr_reg(ADDR_ACC, 32'h3c);
            wr_reg(ADDR_STATUS, {29'h3, ~r.z, 2'h0});
            pc0 = pc;
            wr_reg(ADDR_INSTR, mk(r.op, r.dest, r.fa, 9'h0));
            if (r.op == clear_accumulator_op ||
                (r.op != clear_file_op && !r.dest)) begin
                rd_chk(ADDR_ACC, {24'h0, r.res});
                rd_chk(fad(r.fa), {24'h0, r.init});
            end else begin
                rd_chk(fad(r.fa), {24'h0, r.res});
                rd_chk(ADDR_ACC, 32'h3c);
            end
            rd_chk(ADDR_STATUS, {29'h3, r.z, 2'h0});
            chk({21'h0, pc}, {21'h0, pc0 + 11'h1});
        end
        tend("table");
        wr_reg(ADDR_STATUS, 32'h5c);
        pc0 = pc;
        n_push = 0;
        wr_reg(ADDR_INSTR, mk(call_op, 1'b0, 5'h0, 9'h1ab));
        rd_chk(ADDR_PC, {21'h0, 2'b10, 1'b0, 8'hab});
        rd_chk(ADDR_TOS, {21'h0, pc0 + 11'h1});
        chk({21'h0, stk}, {21'h0, pc0 + 11'h1});
        chk(n_push, 32'h1);
        rd_chk(ADDR_STATUS, 32'h5c);
        tend("call");
        wr_reg(ADDR_STATUS, 32'h38);
        wr_reg(ADDR_INSTR, mk(jump_op, 1'b0, 5'h0, 9'h1cd));
        rd_chk(ADDR_PC, 32'h3cd);
        chk(n_push, 32'h1);
        tend("jump");
        for (int k = 0; k < 2; k++) begin
            wr_reg(ADDR_CTRL, k);
            wr_reg(ADDR_STATUS, 32'h04);
            n_wdt = 0;
            n_presc = 0;
            wr_reg(ADDR_INSTR, mk(watchdog_clear_op, 1'b0, 5'h0, 9'h0));
            rd_chk(ADDR_STATUS, 32'h1c);
            repeat (3) @(posedge clk);
            chk(n_wdt, 32'h1);
            chk(n_presc, k);
        end
        tend("watchdog");
        apb(1'b1, 12'h040, 32'h55, d, e);
        chk({31'h0, e}, 32'h1);
        pc0 = pc;
        wr_reg(ADDR_PC, 32'h7ff);
        chk({21'h0, pc}, {21'h0, pc0});
        tend("refusals");
        // Enable low must hold off the answer until it returns
        ce <= 1'b0;
        fork
            apb(1'b1, ADDR_ACC, 32'h77, d, e);
            begin
                repeat (4) @(posedge clk);
                chk({31'h0, pready}, 32'h0);
                ce <= 1'b1;
            end
        join
        rd_chk(ADDR_ACC, 32'h77);
        tend("enable");
        // Second reset in mid-run must restore the accumulator, status, file register and PC defaults
        wr_reg(ADDR_ACC, 32'h3c);
        wr_reg(fad(5'h02), 32'h9);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_ACC, 32'h0);
        rd_chk(ADDR_STATUS, 32'h18);
        rd_chk(fad(5'h02), 32'h0);
        chk({21'h0, pc}, 32'h0);
        tend("second reset");
        test_done();
    end
endmodule : cce_exec_tb_top
